// >>> design/uep_cfg.svh
// Constants of the stream endpoint pair: offsets, bits, limits.
// Assumes inclusion by the package and the testbench.
`ifndef UEP_CFG_SVH
`define UEP_CFG_SVH
`define UEP_A_TXD   6'h29
`define UEP_A_TXS   6'h2a
`define UEP_A_TXC   6'h2b
`define UEP_A_RXD   6'h2d
`define UEP_A_RXS   6'h2e
`define UEP_A_RXC   6'h2f
`define UEP_EN      0
`define UEP_LAST    1
`define UEP_TGL     2
`define UEP_FLUSH   3
`define UEP_RFF     4
`define UEP_IGNSET  2
`define UEP_IGNMSK  7
`define UEP_WL      6:5
`define UEP_IX      5:0
`define UEP_ERR     3
`define UEP_RXC_MSK 8'h6d
`define UEP_DEPTH   7'h40
`define UEP_TC_MAX  7'h1f
`define UEP_RC_MAX  7'h0f
`define UEP_LIM1    7'h04
`define UEP_LIM2    7'h08
`define UEP_LIM3    7'h10
`define UEP_PID_D0  8'hc3
`define UEP_PID_D1  8'h4b
`define UEP_BUF_D   8
`endif

// >>> design/uep_pkg.sv
// Types of the stream endpoint pair.
// Assumes the constants header is on the include path.
`include "uep_cfg.svh"
package uep_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} uep_tx_st_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } uep_reg_req_t;
  typedef struct packed {
    logic       start;
    logic       setup;
    logic       pid1;
    logic       byte_vld;
    logic [7:0] data;
    logic       good;
    logic       err;
    logic       ack_sent;
  } uep_rx_in_t;
  typedef struct packed {
    uep_tx_st_t       txs;
    logic [7:0]       txc, rxc, rdata, pid;
    logic [63:0][7:0] tmem, rmem;
    logic [6:0]       twp, trp, tsv, rwp, rrp;
    logic             urun, ack, done, armed, tstart, eop, stuff, tstall, twarn;
    logic             ract, rwait, rsetup, rpid1, rgot, rstall, rack, rwarn;
    logic             bval, azlp;
    logic [3:0]       sta, stb;
  } uep_state_t;
endpackage

// >>> design/uep_fifo.sv
// Small FIFO with a registered output word.
// Assumes one clock; clr empties it at once.
`timescale 1ns/1ps
`default_nettype none
module uep_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clr,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready,
  output logic              empty
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp, rp;
    logic                ov;
    logic [W-1:0]        od;
  } uep_fifo_st_t;
  uep_fifo_st_t s, n;
  logic [AW:0]  cnt;
  // Push, pop into the output stage
  always_comb begin
    n = s;
    cnt = AW'(0) + (s.wp - s.rp);
    in_ready = (cnt != (AW+1)'(D));
    if (out_ready) n.ov = 1'b0;
    if ((!s.ov || out_ready) && cnt != '0) begin
      n.od = s.mem[s.rp[AW-1:0]];
      n.ov = 1'b1;
      n.rp = s.rp + 1'b1;
    end
    if (in_valid && in_ready) begin
      n.mem[s.wp[AW-1:0]] = in_data;
      n.wp = s.wp + 1'b1;
    end
    if (clr) begin
      n.wp = '0;
      n.rp = '0;
      n.ov = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) s <= '0;
    else s <= n;
  end
  assign out_valid = s.ov;
  assign out_data  = s.od;
  assign empty     = !s.ov && (s.wp == s.rp);
endmodule
`default_nettype wire

// >>> design/uep_endpoint.sv
// One transmit and one receive stream endpoint: control and status.
// Assumes a protocol engine on the link side and a byte register port.
`timescale 1ns/1ps
`default_nettype none
module uep_endpoint
  import uep_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire uep_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire logic         ep_iso,
  input  wire logic         ep_stall,
  input  wire logic         frame_number_lsb,
  input  wire logic         sof,
  input  wire logic         in_token,
  input  wire logic         host_ack,
  input  wire logic         tx_pkt_end,
  input  wire logic         tx_byte_ready,
  output logic              tx_start,
  output logic [7:0]        tx_pid,
  output logic              tx_byte_valid,
  output logic [7:0]        tx_byte,
  output logic              tx_eop_req,
  output logic              tx_force_stuff,
  output logic              tx_stall_hs,
  input  wire uep_rx_in_t   rx,
  output logic              rx_ack_req,
  output logic              rx_stall_hs,
  output logic              transmit_warning_event,
  output logic              rx_warning_event
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Warning limit decode
  function automatic logic [6:0] uep_lim(input logic [1:0] sel);
    unique case (sel)
      2'h0: return 7'h00;
      2'h1: return `UEP_LIM1;
      2'h2: return `UEP_LIM2;
      2'h3: return `UEP_LIM3;
    endcase
  endfunction

  // Saturating count
  function automatic logic [6:0] uep_sat(input logic [6:0] v,
                                         input logic [6:0] m);
    return (v > m) ? m : v;
  endfunction

  uep_state_t s, n;
  logic [6:0] tcnt;
  logic [6:0] tfree;
  logic [6:0] tfree_s;
  logic [6:0] rcnt;
  logic [6:0] rcnt_s;
  logic [6:0] rfree;
  logic       match;
  logic       qual;
  logic       upd;
  logic [3:0] nst;
  logic       buf_push;
  logic       buf_clr;
  logic [7:0] buf_din;
  logic       buf_rdy;
  logic       buf_empty;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.tstart = 1'b0;
    n.eop = 1'b0;
    n.stuff = 1'b0;
    n.tstall = 1'b0;
    n.rstall = 1'b0;
    n.rack = 1'b0;
    n.rdata = 8'h00;
    buf_push = 1'b0;
    buf_clr = 1'b0;
    buf_din = 8'h00;
    upd = 1'b0;
    nst = 4'h0;
    tcnt = 7'(s.twp - s.trp);
    tfree = 7'(`UEP_DEPTH - tcnt);
    tfree_s = uep_sat(tfree, `UEP_TC_MAX);
    rcnt = 7'(s.rwp - s.rrp);
    rcnt_s = uep_sat(rcnt, `UEP_RC_MAX);
    rfree = 7'(`UEP_DEPTH - rcnt);
    match = (s.txc[`UEP_TGL] == frame_number_lsb);
    qual = !ep_iso || s.txc[`UEP_IGNMSK] || match;

    // Register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `UEP_A_TXD: begin
          if (tcnt != `UEP_DEPTH) begin
            n.tmem[s.twp[`UEP_IX]] = reg_req.wdata;
            n.twp = 7'(s.twp + 7'h01);
          end
        end
        `UEP_A_TXC: begin
          if (reg_req.wdata[`UEP_LAST] && !s.txc[`UEP_LAST]) begin
            n.tsv = s.trp;
          end
          n.txc = reg_req.wdata;
          n.txc[`UEP_FLUSH] = reg_req.wdata[`UEP_FLUSH] | s.txc[`UEP_FLUSH];
          n.txc[`UEP_RFF] = reg_req.wdata[`UEP_RFF] | s.txc[`UEP_RFF];
        end
        `UEP_A_RXC: begin
          n.rxc = reg_req.wdata & `UEP_RXC_MSK;
          n.rxc[`UEP_FLUSH] = n.rxc[`UEP_FLUSH] | s.rxc[`UEP_FLUSH];
        end
        default: ;
      endcase
    end

    // Register reads and their side effects
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `UEP_A_TXS: begin
          n.rdata = {s.urun, s.ack, s.done, tfree_s[4:0]};
          n.urun = 1'b0;
          n.ack = 1'b0;
          n.done = 1'b0;
        end
        `UEP_A_TXC: n.rdata = s.txc;
        `UEP_A_RXC: n.rdata = s.rxc;
        `UEP_A_RXS: begin
          n.rdata = {s.sta, rcnt_s[3:0]};
          if (s.bval) begin
            n.sta = s.stb;
            n.bval = 1'b0;
          end else begin
            n.sta = 4'h0;
          end
          n.azlp = 1'b0;
        end
        `UEP_A_RXD: begin
          if (rcnt != 7'h00) begin
            n.rdata = s.rmem[s.rrp[`UEP_IX]];
            n.rrp = 7'(s.rrp + 7'h01);
          end
        end
        default: ;
      endcase
    end

    // Arm the iso frame window
    if (ep_iso && s.txc[`UEP_EN] && !s.txc[`UEP_IGNMSK] && match
        && s.txs == TX_IDLE) begin
      n.armed = 1'b1;
    end

    // Transmit sequencing
    unique case (s.txs)
      TX_IDLE: begin
        if (s.txc[`UEP_FLUSH]) begin
          n.twp = 7'h00;
          n.trp = 7'h00;
          n.tsv = 7'h00;
          n.txc[`UEP_LAST] = 1'b0;
          n.txc[`UEP_FLUSH] = 1'b0;
          buf_clr = 1'b1;
        end else if (s.txc[`UEP_RFF]) begin
          n.trp = s.tsv;
          n.txc[`UEP_RFF] = 1'b0;
          buf_clr = 1'b1;
        end else if (in_token && s.txc[`UEP_EN]) begin
          if (ep_stall) begin
            n.tstall = 1'b1;
            n.txc[`UEP_EN] = 1'b0;
            n.done = 1'b1;
          end else if (qual) begin
            n.tstart = 1'b1;
            n.armed = 1'b0;
            n.txs = TX_SEND;
            // Iso forces DATA0
            n.pid = (ep_iso || !s.txc[`UEP_TGL]) ? `UEP_PID_D0 : `UEP_PID_D1;
          end
        end
      end
      TX_SEND: begin
        if (tcnt != 7'h00) begin
          if (buf_rdy) begin
            buf_push = 1'b1;
            buf_din = s.tmem[s.trp[`UEP_IX]];
            n.trp = 7'(s.trp + 7'h01);
          end
        end else if (buf_empty) begin
          if (s.txc[`UEP_LAST]) begin
            n.eop = 1'b1;
          end else begin
            n.stuff = 1'b1;
            n.urun = 1'b1;
          end
          n.txs = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (tx_pkt_end) begin
          n.txs = TX_IDLE;
          n.txc[`UEP_EN] = 1'b0;
          n.txc[`UEP_LAST] = 1'b0;
          n.done = 1'b1;
          n.ack = ep_iso;
        end
      end
    endcase

    // Host handshake after a non-iso packet
    if (host_ack && !ep_iso) n.ack = 1'b1;

    // Frame passed with no IN token served
    if (sof) begin
      n.armed = 1'b0;
      if (s.armed && s.txs == TX_IDLE && !n.tstart) begin
        n.twp = 7'h00;
        n.trp = 7'h00;
        n.tsv = 7'h00;
        n.txc[`UEP_EN] = 1'b0;
        n.txc[`UEP_LAST] = 1'b0;
        n.ack = 1'b0;
        n.done = 1'b1;
        buf_clr = 1'b1;
      end
    end

    // Warning levels
    n.twarn = s.txc[`UEP_EN] && (s.txc[`UEP_WL] != 2'h0)
              && (tcnt <= uep_lim(s.txc[`UEP_WL]));
    n.rwarn = (s.rxc[`UEP_WL] != 2'h0)
              && (rfree <= uep_lim(s.rxc[`UEP_WL]));

    // Receive packet start and acceptance
    if (rx.start) begin
      n.rsetup = rx.setup;
      n.rpid1 = rx.pid1;
      n.rgot = 1'b0;
      if (rx.setup) begin
        n.ract = !s.rxc[`UEP_IGNSET];
      end else if (s.rxc[`UEP_EN] && ep_stall) begin
        n.rstall = 1'b1;
        n.rxc[`UEP_EN] = 1'b0;
        n.ract = 1'b0;
      end else begin
        n.ract = s.rxc[`UEP_EN];
      end
    end

    // Receive bytes into the endpoint memory
    if (s.ract && rx.byte_vld && rcnt != `UEP_DEPTH) begin
      n.rmem[s.rwp[`UEP_IX]] = rx.data;
      n.rwp = 7'(s.rwp + 7'h01);
      n.rgot = 1'b1;
    end

    // Receive packet end
    if (s.ract && rx.err) begin
      n.ract = 1'b0;
      n.sta[`UEP_ERR] = 1'b1;
    end else if (s.ract && rx.good) begin
      n.ract = 1'b0;
      if (ep_iso) begin
        upd = 1'b1;
      end else begin
        n.rack = 1'b1;
        n.rwait = 1'b1;
      end
    end
    if (s.rwait && rx.ack_sent) begin
      n.rwait = 1'b0;
      upd = 1'b1;
    end

    // Status update, second copy behind a zero-length status
    if (upd) begin
      nst = {1'b0, s.rsetup, ep_iso ? frame_number_lsb : s.rpid1, 1'b1};
      if (!s.rsetup) n.rxc[`UEP_EN] = 1'b0;
      if (n.azlp && s.rsetup && s.rgot) begin
        n.stb = nst;
        n.bval = 1'b1;
      end else begin
        n.sta = n.sta | nst;
        n.azlp = !s.rgot;
      end
    end

    // Receive flush once reception is over
    if (s.rxc[`UEP_FLUSH] && !s.ract && !s.rwait && !rx.start) begin
      n.rwp = 7'h00;
      n.rrp = 7'h00;
      n.rxc[`UEP_FLUSH] = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) s <= '0;
    else s <= n;
  end

  // ----------------------------------------
  // Link-side byte buffer
  // ----------------------------------------
  uep_fifo #(
    .W (8),
    .D (`UEP_BUF_D)
  ) u_buf (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .clr       (buf_clr),
    .in_valid  (buf_push),
    .in_data   (buf_din),
    .in_ready  (buf_rdy),
    .out_valid (tx_byte_valid),
    .out_data  (tx_byte),
    .out_ready (tx_byte_ready),
    .empty     (buf_empty)
  );

  // Registered outputs
  assign reg_rdata              = s.rdata;
  assign tx_start               = s.tstart;
  assign tx_pid                 = s.pid;
  assign tx_eop_req             = s.eop;
  assign tx_force_stuff         = s.stuff;
  assign tx_stall_hs            = s.tstall;
  assign rx_ack_req             = s.rack;
  assign rx_stall_hs            = s.rstall;
  assign transmit_warning_event = s.twarn;
  assign rx_warning_event       = s.rwarn;
endmodule
`default_nettype wire

// >>> verif/uep_host_model.sv
// Link engine and host model: takes payload bytes, ends packets.
// Assumes the endpoint's stream outputs; slow halves byte acceptance.
`timescale 1ns/1ps
`default_nettype none
module uep_host_model (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       slow,
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_eop_req,
  input  wire logic       tx_force_stuff,
  output logic            tx_byte_ready,
  output logic            tx_pkt_end,
  output logic [7:0]      n_got,
  output logic [7:0]      last_got,
  output logic            forced
);
  logic [1:0] tail;
  logic       ph;
  // ----
  // Byte sink and packet end
  // ----
  assign tx_byte_ready = !slow || ph;
  // Only payload arrives; CRC16 and EOP follow the end request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph <= 1'b0;
      tail <= 2'h0;
      tx_pkt_end <= 1'b0;
      n_got <= 8'h00;
      last_got <= 8'h00;
      forced <= 1'b0;
    end else begin
      ph <= !ph;
      tx_pkt_end <= (tail == 2'h1);
      if (tail != 2'h0) tail <= tail - 2'h1;
      if (tx_byte_valid && tx_byte_ready) begin
        n_got <= n_got + 8'h01;
        last_got <= tx_byte;
      end
      if (tx_eop_req || tx_force_stuff) begin
        tail <= 2'h2;
        forced <= tx_force_stuff;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/uep_endpoint_asserts.sv
// Port checker of the stream endpoint pair.
// Assumes binding to uep_endpoint; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module uep_endpoint_asserts
  import uep_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         resetn,
  input wire uep_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire logic         ep_iso,
  input wire logic         ep_stall,
  input wire logic         in_token,
  input wire logic         tx_byte_ready,
  input wire logic         tx_start,
  input wire logic [7:0]   tx_pid,
  input wire logic         tx_byte_valid,
  input wire logic [7:0]   tx_byte,
  input wire logic         tx_eop_req,
  input wire logic         tx_force_stuff,
  input wire logic         tx_stall_hs,
  input wire uep_rx_in_t   rx,
  input wire logic         rx_ack_req,
  input wire logic         rx_stall_hs
);
  // ----
  // Port properties
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_start_cause;
    tx_start |-> $past(in_token) && !$past(ep_stall);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("packet start without token");
  property p_stall_cause;
    tx_stall_hs |-> $past(in_token) && $past(ep_stall);
  endproperty
  a_stall_cause: assert property (p_stall_cause)
    else $error("stall without stalled token");
  property p_iso_pid;
    tx_start && ep_iso |-> tx_pid == 8'hc3;
  endproperty
  a_iso_pid: assert property (p_iso_pid)
    else $error("iso packet not DATA0");
  property p_pid_code;
    tx_start |-> tx_pid == 8'hc3 || tx_pid == 8'h4b;
  endproperty
  a_pid_code: assert property (p_pid_code)
    else $error("bad data PID");
  property p_one_end;
    tx_eop_req |=> !tx_eop_req && !tx_force_stuff;
  endproperty
  a_one_end: assert property (p_one_end)
    else $error("packet ended twice");
  property p_ack_req;
    rx_ack_req |-> $past(rx.good) && !ep_iso;
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack request without good packet");
  property p_rx_stall;
    rx_stall_hs |-> $past(rx.start);
  endproperty
  a_rx_stall: assert property (p_rx_stall)
    else $error("receive stall without packet");
  property p_hold;
    tx_byte_valid && !tx_byte_ready |=> tx_byte_valid && $stable(tx_byte);
  endproperty
  a_hold: assert property (p_hold)
    else $error("payload byte dropped");
endmodule
bind uep_endpoint uep_endpoint_asserts u_chk (.clk_sys, .resetn, .reg_req, .reg_rdata,
  .ep_iso, .ep_stall, .in_token, .tx_byte_ready, .tx_start, .tx_pid, .tx_byte_valid,
  .tx_byte, .tx_eop_req, .tx_force_stuff, .tx_stall_hs, .rx, .rx_ack_req, .rx_stall_hs);
`default_nettype wire

// >>> verif/tb.sv
// Testbench of the stream endpoint pair.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "uep_cfg.svh"
module tb;
  import uep_pkg::*;
  logic         clk_sys, resetn, ep_iso, ep_stall, frame_number_lsb, sof;
  logic         in_token, host_ack, tx_pkt_end, tx_byte_ready, tx_start;
  logic         tx_byte_valid, tx_eop_req, tx_force_stuff, tx_stall_hs;
  logic         rx_ack_req, rx_stall_hs, transmit_warning_event, rx_warning_event;
  logic         slow, forced;
  logic [7:0]   reg_rdata, tx_pid, tx_byte, n_got, last_got, pid_seen, b0;
  uep_reg_req_t reg_req;
  uep_rx_in_t   rx;
  int           failures = 0, cmp_count = 0, n_start = 0, n_stall = 0;
  int           n_ackreq = 0, n_end = 0, n_rstall = 0;
  uep_endpoint u_uep_endpoint (.clk_sys, .resetn, .reg_req, .reg_rdata, .ep_iso,
    .ep_stall, .frame_number_lsb, .sof, .in_token, .host_ack, .tx_pkt_end,
    .tx_byte_ready, .tx_start, .tx_pid, .tx_byte_valid, .tx_byte, .tx_eop_req,
    .tx_force_stuff, .tx_stall_hs, .rx, .rx_ack_req, .rx_stall_hs,
    .transmit_warning_event, .rx_warning_event);
  uep_host_model u_uep_host_model (.clk_sys, .resetn, .slow, .tx_byte_valid, .tx_byte,
    .tx_eop_req, .tx_force_stuff, .tx_byte_ready, .tx_pkt_end, .n_got, .last_got,
    .forced);
  // ----
  // Clock, pulse counters, tasks
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_start <= n_start + tx_start;
    n_stall <= n_stall + tx_stall_hs;
    n_ackreq <= n_ackreq + rx_ack_req;
    n_end <= n_end + tx_pkt_end;
    n_rstall <= n_rstall + rx_stall_hs;
    if (tx_start) pid_seen <= tx_pid;
  end
  task automatic give_verdict;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_req = {1'b1, 1'b0, a, d};
    cyc(1);
    reg_req = '0;
    cyc(1);
  endtask
  task automatic rdc(input string what, input logic [5:0] a, input logic [7:0] e);
    reg_req = {1'b0, 1'b1, a, 8'h00};
    cyc(1);
    check(what, reg_rdata, e);
    reg_req = '0;
    cyc(1);
  endtask
  task automatic token;
    in_token = 1'b1;
    cyc(1);
    in_token = 1'b0;
  endtask
  // One received packet: start, payload, good end, ACK sent
  task automatic rx_pkt(input logic st, input logic p1, input int nb, input int ak);
    rx.start = 1'b1;
    rx.setup = st;
    rx.pid1 = p1;
    cyc(1);
    rx.start = 1'b0;
    rx.byte_vld = (nb != 0);
    for (int k = 0; k < nb; k++) begin
      rx.data = 8'h40 + 8'(k);
      cyc(1);
    end
    rx.byte_vld = 1'b0;
    rx.good = 1'b1;
    cyc(1);
    rx.good = 1'b0;
    wait_cnt(n_ackreq, ak);
    rx.ack_sent = 1'b1;
    cyc(1);
    rx.ack_sent = 1'b0;
    cyc(1);
  endtask
  task automatic wait_cnt(ref int c, input int t);
    int i;
    for (i = 0; i < 300 && c < t; i++) cyc(1);
    if (c < t) begin
      failures++;
      $display("BAD wait exp %0d seen %0d", t, c);
      give_verdict();
    end
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    resetn = 1'b0;
    reg_req = '0;
    rx = '0;
    {ep_iso, ep_stall, frame_number_lsb, sof, in_token, host_ack, slow} = '0;
    cyc(10);
    resetn = 1'b1;
    cyc(1);
    rdc("txc", `UEP_A_TXC, 8'h00);
    rdc("txs", `UEP_A_TXS, 8'h1f);
    rdc("rxs", `UEP_A_RXS, 8'h00);
    rdc("unmapped", 6'h00, 8'h00);
    // Non-iso packet of three bytes, slow engine
    slow = 1'b1;
    for (int k = 0; k < 3; k++) wr(`UEP_A_TXD, 8'ha0 + 8'(k));
    wr(`UEP_A_TXC, 8'h07);
    b0 = n_got;
    token();
    wait_cnt(n_end, 1);
    check("pid1", pid_seen, 8'h4b);
    check("bytes", n_got - b0, 8'h03);
    check("last", last_got, 8'ha2);
    host_ack = 1'b1;
    cyc(1);
    host_ack = 1'b0;
    rdc("txs_ack", `UEP_A_TXS, 8'h7f);
    rdc("txs_clr", `UEP_A_TXS, 8'h1f);
    rdc("txc_end", `UEP_A_TXC, 8'h04);
    // Iso: frame mismatch holds, ignore mask releases
    ep_iso = 1'b1;
    slow = 1'b0;
    wr(`UEP_A_TXD, 8'h5a);
    wr(`UEP_A_TXC, 8'h07);
    token();
    cyc(4);
    check("iso_hold", 8'(n_start), 8'h01);
    wr(`UEP_A_TXC, 8'h87);
    token();
    wait_cnt(n_end, 2);
    check("iso_pid", pid_seen, 8'hc3);
    rdc("txs_iso", `UEP_A_TXS, 8'h7f);
    // Iso: matching frame without token, flushed at frame start
    frame_number_lsb = 1'b1;
    wr(`UEP_A_TXD, 8'h11);
    wr(`UEP_A_TXC, 8'h07);
    sof = 1'b1;
    cyc(1);
    sof = 1'b0;
    cyc(2);
    rdc("txs_sof", `UEP_A_TXS, 8'h3f);
    rdc("txc_sof", `UEP_A_TXC, 8'h04);
    ep_iso = 1'b0;
    // Underrun: no last byte mark
    wr(`UEP_A_TXD, 8'h21);
    wr(`UEP_A_TXC, 8'h01);
    token();
    wait_cnt(n_end, 3);
    check("forced", {7'h00, forced}, 8'h01);
    check("pid0", pid_seen, 8'hc3);
    rdc("txs_urun", `UEP_A_TXS, 8'hbf);
    rdc("txs_uclr", `UEP_A_TXS, 8'h1f);
    // Stall answer to a token
    ep_stall = 1'b1;
    wr(`UEP_A_TXC, 8'h01);
    token();
    wait_cnt(n_stall, 1);
    ep_stall = 1'b0;
    rdc("txc_stall", `UEP_A_TXC, 8'h00);
    rdc("txs_stall", `UEP_A_TXS, 8'h3f);
    // Flush of a part-filled transmit memory
    for (int k = 0; k < 40; k++) wr(`UEP_A_TXD, 8'(k));
    rdc("txs_fill", `UEP_A_TXS, 8'h18);
    wr(`UEP_A_TXC, 8'h08);
    cyc(2);
    rdc("txs_flush", `UEP_A_TXS, 8'h1f);
    rdc("txc_flush", `UEP_A_TXC, 8'h00);
    // Receive twenty bytes with DATA1
    wr(`UEP_A_RXC, 8'h01);
    rx.start = 1'b1;
    rx.pid1 = 1'b1;
    cyc(1);
    rx.start = 1'b0;
    rx.byte_vld = 1'b1;
    for (int k = 0; k < 20; k++) begin
      rx.data = 8'h30 + 8'(k);
      cyc(1);
    end
    rx.byte_vld = 1'b0;
    rx.good = 1'b1;
    cyc(1);
    rx.good = 1'b0;
    wait_cnt(n_ackreq, 1);
    rx.ack_sent = 1'b1;
    cyc(1);
    rx.ack_sent = 1'b0;
    cyc(1);
    rdc("rxs_pkt", `UEP_A_RXS, 8'h3f);
    rdc("rxc_en", `UEP_A_RXC, 8'h00);
    rdc("rxs_clr", `UEP_A_RXS, 8'h0f);
    rdc("rxd", `UEP_A_RXD, 8'h30);
    wr(`UEP_A_RXC, 8'h08);
    cyc(2);
    rdc("rxs_flush", `UEP_A_RXS, 8'h00);
    // Media error
    wr(`UEP_A_RXC, 8'h01);
    rx.start = 1'b1;
    cyc(1);
    rx.start = 1'b0;
    rx.err = 1'b1;
    cyc(1);
    rx.err = 1'b0;
    cyc(2);
    rdc("rxs_err", `UEP_A_RXS, 8'h80);
    wr(`UEP_A_RXC, 8'hf7);
    rdc("rxc_bits", `UEP_A_RXC, 8'h65);
    // Transmit warning gated by enable, then refill resend
    for (int k = 0; k < 3; k++) wr(`UEP_A_TXD, 8'h60 + 8'(k));
    wr(`UEP_A_TXC, 8'h20);
    check("twarn_off", {7'h00, transmit_warning_event}, 8'h00);
    wr(`UEP_A_TXC, 8'h23);
    check("twarn_on", {7'h00, transmit_warning_event}, 8'h01);
    b0 = n_got;
    token();
    wait_cnt(n_end, 4);
    check("first", n_got - b0, 8'h03);
    wr(`UEP_A_TXC, 8'h10);
    wr(`UEP_A_TXC, 8'h03);
    token();
    wait_cnt(n_end, 5);
    check("refill", n_got - b0, 8'h06);
    check("refill_last", last_got, 8'h62);
    // Receive warning at sixteen free bytes
    wr(`UEP_A_RXC, 8'h61);
    check("rwarn_off", {7'h00, rx_warning_event}, 8'h00);
    rx_pkt(1'b0, 1'b0, 48, 2);
    check("rwarn_on", {7'h00, rx_warning_event}, 8'h01);
    rdc("rxs_48", `UEP_A_RXS, 8'h1f);
    wr(`UEP_A_RXC, 8'h08);
    cyc(2);
    // Zero-length packet, then SETUP with data: two status copies
    wr(`UEP_A_RXC, 8'h01);
    rx_pkt(1'b0, 1'b1, 0, 3);
    rx_pkt(1'b1, 1'b0, 1, 4);
    rdc("rxs_zlp", `UEP_A_RXS, 8'h31);
    rdc("rxs_setup", `UEP_A_RXS, 8'h51);
    // Receive stall clears enable
    ep_stall = 1'b1;
    wr(`UEP_A_RXC, 8'h01);
    rx.setup = 1'b0;
    rx.start = 1'b1;
    cyc(1);
    rx.start = 1'b0;
    wait_cnt(n_rstall, 1);
    ep_stall = 1'b0;
    rdc("rxc_stall", `UEP_A_RXC, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
